// ===== hw/srfp_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a flush.
// Assumes one clock; flush wins over a push in the same cycle.
`timescale 1ns/1ps
module srfp_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 16
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic         flush_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic      [W-1:0] out_data_o,
    input  wire logic         out_ready_i
);
    localparam int unsigned AW = $clog2(D);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } srfp_fifo_t;
    srfp_fifo_t r_ff, nxt_r;
    logic push;
    logic pop;
    always_comb begin
        push  = in_valid_i && in_ready_o;
        pop   = out_valid_o && out_ready_i;
        nxt_r = r_ff;
        if (flush_i) begin
            nxt_r.wp  = '0;
            nxt_r.rp  = '0;
            nxt_r.cnt = '0;
        end else begin
            if (push) begin
                nxt_r.mem[r_ff.wp] = in_data_i;
                nxt_r.wp = (r_ff.wp == AW'(D - 1)) ? '0 : r_ff.wp + 1'b1;
            end
            if (pop) begin
                nxt_r.rp = (r_ff.rp == AW'(D - 1)) ? '0 : r_ff.rp + 1'b1;
            end
            nxt_r.cnt = r_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end
    assign in_ready_o  = (r_ff.cnt != (AW+1)'(D));
    assign out_valid_o = (r_ff.cnt != '0);
    assign out_data_o  = r_ff.mem[r_ff.rp];
endmodule // srfp_fifo

// ===== hw/srfp_main.sv
// Serial flash command logic: protection decode, write status, reads.
// Assumes pins are asynchronous and serial clock is well below clk_i/4.
// Operation
// - Top/bottom low: top 2^(n-1) sectors protected for n 1..10, none at 0, all above
// - Top/bottom high: sectors 0..2^(n-1)-1 protected for n 1..10, none 0, all above
// - Sectors in the protected range are read-only to program and erase
// - Write status sets protect level and top/bottom; WEL and WIP untouched by data
// - Self-timed status cycle starts at chip select rise, ends within 8 ms
// - Status read shows busy 1 during the cycle, 0 after
// - Read: opcode then 3 or 4 address bytes, captured on rising clock
// - Read data goes out MSB first, changing on falling clock edges
// - Address increments per byte and wraps from top to zero
// - Plain read during program or erase is ignored, cycle continues
// - Fast read: opcode, address, dummy cycles, then data on falling edges
// - Raising chip select stops fast-read output at any time
// - Fast read during a busy cycle does not execute
// - Four-byte mode carries 32 address bits
`timescale 1ns/1ps
module srfp_main
    import srfp_pkg::*;
#(
    parameter logic [7:0]  OP_READ   = OP_READ_DEF,
    parameter logic [7:0]  OP_FAST   = OP_FAST_DEF,
    parameter logic [7:0]  OP_RDSR   = OP_RDSR_DEF,
    parameter logic [7:0]  OP_WRSR   = OP_WRSR_DEF,
    parameter logic [7:0]  OP_WREN   = OP_WREN_DEF,
    parameter int unsigned DUMMY     = DUMMY_DEF,
    parameter int unsigned WS_CYCLES = WS_CYC,
    parameter logic [31:0] MEM_TOP   = MEM_TOP_DEF
) (
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    input  wire logic                 cs_n_i,
    input  wire logic                 serial_clock_pin_i,
    input  wire logic                 serial_in_line_i,
    output logic                      serial_out_line_o,
    output logic                      serial_out_oe_o,
    input  wire logic                 addr4_i,
    input  wire logic                 ext_busy_i,
    input  wire logic [SECT_BITS-1:0] sector_query_i,
    output logic                      sector_protected_o,
    output logic      [3:0]           block_protect_level_o,
    output logic                      top_bottom_select_o,
    output logic                      status_wel_o,
    output logic                      status_wip_o,
    output logic                      fetch_req_o,
    output logic      [31:0]          fetch_addr_o,
    input  wire logic                 fetch_valid_i,
    input  wire logic [7:0]           fetch_data_i
);
    localparam int unsigned TW = $clog2(WS_CYCLES + 1);

    typedef struct packed {
        srfp_st_t    st;
        logic        sclk_q;
        logic [7:0]  sh;
        logic [5:0]  cnt;
        logic        fast;
        logic [31:0] addr;
        logic [7:0]  obuf;
        logic [2:0]  obit;
        logic        so;
        logic        oe;
        logic        wel;
        logic [3:0]  bp;
        logic        topbot;
        logic [3:0]  nbp;
        logic        ntopbot;
        logic        busy;
        logic        wip;
        logic [TW-1:0] timer;
        logic        fetch_req;
        logic        fetch_pend;
        logic        fetch_live;
        logic [31:0] fetch_addr;
        logic        prot;
    } srfp_main_t;

    srfp_main_t r_ff, nxt_r;

    logic [2:0] pins_s;
    logic       s_sclk;
    logic       s_csn;
    logic       s_si;
    logic       rise;
    logic       fall;
    logic [7:0] opc;
    logic [5:0] alen;
    logic       fifo_flush;
    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic       fifo_pop;
    logic [7:0] stat_byte;

    srfp_sync #(
        .W       (3),
        .RST_VAL (PIN_IDLE)
    ) u_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    ({serial_clock_pin_i, cs_n_i, serial_in_line_i}),
        .q_o    (pins_s)
    );

    assign s_sclk = pins_s[2];
    assign s_csn  = pins_s[1];
    assign s_si   = pins_s[0];
    assign rise   = s_sclk && !r_ff.sclk_q && !s_csn;
    assign fall   = !s_sclk && r_ff.sclk_q && !s_csn;
    assign opc    = {r_ff.sh[6:0], s_si};
    assign alen   = addr4_i ? 6'(ADDR4_BITS) : 6'(ADDR3_BITS);

    srfp_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_fifo (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .flush_i     (fifo_flush),
        .in_valid_i  (fifo_in_valid),
        .in_data_i   (fetch_data_i),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_pop)
    );

    // Sector protection decode
    function automatic logic prot_of(input logic [3:0] bp, input logic topbot,
                                     input logic [SECT_BITS-1:0] sec);
        logic [10:0] span;
        span = 11'h001 << (bp - 4'h1);
        if (bp == 4'h0) begin
            prot_of = 1'b0;
        end else if (bp >= BP_ALL) begin
            prot_of = 1'b1;
        end else if (topbot) begin
            prot_of = ({1'b0, sec} < span);
        end else begin
            prot_of = ({1'b0, sec} >= (SECT_NUM - span));
        end
    endfunction

    always_comb begin
        stat_byte         = 8'h00;
        stat_byte[SR_WIP] = r_ff.wip;
        stat_byte[SR_WEL] = r_ff.wel;
        stat_byte[SR_LVL_LO +: 3] = r_ff.bp[2:0];
        stat_byte[SR_TOPBOT]      = r_ff.topbot;
        stat_byte[SR_LVL_HI]      = r_ff.bp[3];
    end

    assign fifo_in_valid = fetch_valid_i && r_ff.fetch_live;

    always_comb begin
        nxt_r           = r_ff;
        fifo_flush      = 1'b0;
        fifo_pop        = 1'b0;
        nxt_r.sclk_q    = s_sclk;
        nxt_r.fetch_req = 1'b0;
        nxt_r.prot      = prot_of(r_ff.bp, r_ff.topbot, sector_query_i);
        // Self-timed status cycle
        if (r_ff.busy) begin
            if (r_ff.timer == '0) begin
                nxt_r.busy = 1'b0;
                nxt_r.bp   = r_ff.nbp;
                nxt_r.topbot = r_ff.ntopbot;
                nxt_r.wel  = 1'b0;
            end else begin
                nxt_r.timer = r_ff.timer - 1'b1;
            end
        end
        if (s_csn) begin
            nxt_r.oe         = 1'b0;
            nxt_r.st         = ST_OPC;
            nxt_r.cnt        = '0;
            nxt_r.fetch_live = 1'b0;
            fifo_flush       = 1'b1;
            if (r_ff.st == ST_WREN) begin
                nxt_r.wel = 1'b1;
            end
            // Write status needs exactly one data byte and the latch set
            if (r_ff.st == ST_WSR && r_ff.cnt == 6'd8 && r_ff.wel && !r_ff.wip) begin
                nxt_r.busy  = 1'b1;
                nxt_r.timer = TW'(WS_CYCLES - 1);
                nxt_r.nbp     = {r_ff.sh[SR_LVL_HI], r_ff.sh[SR_LVL_LO +: 3]};
                nxt_r.ntopbot = r_ff.sh[SR_TOPBOT];
            end
        end else if (rise) begin
            nxt_r.sh = opc;
            if (r_ff.cnt != 6'h3F) begin
                nxt_r.cnt = r_ff.cnt + 6'd1;
            end
            case (r_ff.st)
                ST_OPC: begin
                    if (r_ff.cnt == 6'd7) begin
                        nxt_r.cnt  = '0;
                        nxt_r.addr = '0;
                        nxt_r.obit = 3'd0;
                        if (opc == OP_READ || opc == OP_FAST) begin
                            nxt_r.fast = (opc == OP_FAST);
                            nxt_r.st = r_ff.wip ? ST_IGN : ST_ADDR;
                        end else if (opc == OP_RDSR) begin
                            nxt_r.st = ST_STAT;
                        end else if (opc == OP_WREN) begin
                            nxt_r.st = r_ff.wip ? ST_IGN : ST_WREN;
                        end else if (opc == OP_WRSR) begin
                            nxt_r.st = r_ff.wip ? ST_IGN : ST_WSR;
                        end else begin
                            nxt_r.st = ST_IGN;
                        end
                    end
                end
                ST_ADDR: begin
                    nxt_r.addr = {r_ff.addr[30:0], s_si};
                    if (r_ff.cnt == alen - 6'd1) begin
                        nxt_r.cnt        = '0;
                        nxt_r.fetch_addr = {r_ff.addr[30:0], s_si};
                        nxt_r.fetch_live = 1'b1;
                        // First fetch leaves at once so a slow answer meets the first bit
                        nxt_r.fetch_req  = 1'b1;
                        nxt_r.fetch_pend = 1'b1;
                        if (r_ff.fast && DUMMY != 0) begin
                            nxt_r.st = ST_DUMMY;
                        end else begin
                            nxt_r.st = ST_DATA;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (r_ff.cnt == 6'(DUMMY - 1)) begin
                        nxt_r.cnt = '0;
                        nxt_r.st  = ST_DATA;
                    end
                end
                ST_WREN: begin
                    nxt_r.st = ST_IGN;
                end
                default: begin
                end
            endcase
        end else if (fall && (r_ff.st == ST_DATA || r_ff.st == ST_STAT)) begin
            nxt_r.oe = 1'b1;
            if (r_ff.obit == 3'd0) begin
                // Byte boundary: load status or the next buffered byte
                if (r_ff.st == ST_STAT) begin
                    nxt_r.so   = stat_byte[7];
                    nxt_r.obuf = {stat_byte[6:0], 1'b0};
                end else begin
                    fifo_pop   = fifo_out_valid;
                    nxt_r.so   = fifo_out_valid ? fifo_out_data[7] : 1'b1;
                    nxt_r.obuf = {fifo_out_data[6:0], 1'b0};
                end
                nxt_r.obit = 3'd7;
            end else begin
                nxt_r.so   = r_ff.obuf[7];
                nxt_r.obuf = {r_ff.obuf[6:0], 1'b0};
                nxt_r.obit = r_ff.obit - 3'd1;
            end
        end
        // Prefetch engine; stalls while the buffer is full
        if (fetch_valid_i) begin
            nxt_r.fetch_pend = 1'b0;
            if (r_ff.fetch_live && !s_csn) begin
                nxt_r.fetch_addr = (r_ff.fetch_addr == MEM_TOP) ? '0 :
                                   r_ff.fetch_addr + 32'd1;
            end
        end else if (r_ff.fetch_live && !r_ff.fetch_pend && fifo_in_ready && !s_csn) begin
            nxt_r.fetch_req  = 1'b1;
            nxt_r.fetch_pend = 1'b1;
        end
        nxt_r.wip = nxt_r.busy || ext_busy_i;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_ff    <= '0;
            r_ff.st <= ST_OPC;
            r_ff.bp <= RST_BP;
            r_ff.topbot <= RST_TOPBOT;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign serial_out_line_o     = r_ff.so;
    assign serial_out_oe_o       = r_ff.oe;
    assign sector_protected_o    = r_ff.prot;
    assign block_protect_level_o = r_ff.bp;
    assign top_bottom_select_o   = r_ff.topbot;
    assign status_wel_o          = r_ff.wel;
    assign status_wip_o          = r_ff.wip;
    assign fetch_req_o           = r_ff.fetch_req;
    assign fetch_addr_o          = r_ff.fetch_addr;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    AST_PROT_TOP: assert property (
        (!r_ff.topbot && r_ff.bp == 4'hA)
        |=> (r_ff.prot == ($past(sector_query_i) >= 10'h200)))
        else $error("top protection range wrong");
    AST_PROT_BOT: assert property (
        (r_ff.topbot && r_ff.bp == 4'h8 && !r_ff.busy)
        |=> (r_ff.prot == ($past(sector_query_i) < 10'h080)))
        else $error("bottom protection range wrong");
    AST_PROT_ALL: assert property (
        (r_ff.bp >= BP_ALL && !r_ff.busy) |=> r_ff.prot)
        else $error("sector writable at full protection");
    AST_WSR_WEL: assert property (
        $rose(r_ff.busy) |-> $past(r_ff.wel) && r_ff.wel)
        else $error("status cycle without latch or latch altered");
    AST_WSR_START: assert property (
        (s_csn && r_ff.st == ST_WSR && r_ff.cnt == 6'd8 && r_ff.wel && !r_ff.wip)
        |=> r_ff.busy ##1 r_ff.wip)
        else $error("status cycle did not start");
    AST_WSR_LEN: assert property (
        r_ff.busy |-> (r_ff.timer < TW'(WS_CYCLES)) && (WS_CYCLES <= WS_MAX_CYC))
        else $error("status cycle too long");
    AST_WIP: assert property (
        $fell(r_ff.busy) |-> ##1 (r_ff.wip == $past(ext_busy_i)))
        else $error("busy flag not cleared after cycle");
    AST_IGN_BUSY: assert property (
        (rise && r_ff.st == ST_OPC && r_ff.cnt == 6'd7 && r_ff.wip &&
         (opc == OP_READ || opc == OP_FAST)) |=> r_ff.st == ST_IGN ##1 !r_ff.oe)
        else $error("read executed while busy");
    AST_CS_STOP: assert property (
        s_csn |=> !r_ff.oe && r_ff.st == ST_OPC)
        else $error("output not stopped by chip select");
    AST_MSB: assert property (
        (fall && r_ff.st == ST_DATA && r_ff.obit == 3'd0 && fifo_out_valid)
        |=> r_ff.so == $past(fifo_out_data[7]))
        else $error("first data bit not the MSB");
    AST_WRAP: assert property (
        (fetch_valid_i && r_ff.fetch_live && !s_csn && r_ff.fetch_addr == MEM_TOP)
        |=> r_ff.fetch_addr == 32'd0)
        else $error("address did not wrap");

    COV_READ: cover property (r_ff.st == ST_DATA && !r_ff.fast && fifo_pop);
    COV_FAST: cover property (r_ff.st == ST_DUMMY ##[1:200] r_ff.st == ST_DATA);
    COV_WSR: cover property ($fell(r_ff.busy));
    COV_STAT: cover property (r_ff.st == ST_STAT && r_ff.wip && r_ff.oe);
endmodule // srfp_main

// ===== hw/srfp_pkg.sv
// Constants for the serial flash protect and read block.
// Assumes a 10 MHz system clock and one 8-bit status byte.
package srfp_pkg;
    localparam int unsigned CLK_MHZ     = 10;
    localparam int unsigned WS_TYP_US   = 5000;
    localparam int unsigned WS_MAX_US   = 8000;
    localparam int unsigned WS_CYC      = WS_TYP_US * CLK_MHZ;
    localparam int unsigned WS_MAX_CYC  = WS_MAX_US * CLK_MHZ;
    localparam int unsigned ADDR3_BITS  = 24;
    localparam int unsigned ADDR4_BITS  = 32;
    localparam int unsigned DUMMY_DEF   = 8;
    localparam int unsigned FIFO_W      = 8;
    localparam int unsigned FIFO_D      = 16;
    localparam int unsigned SECT_BITS   = 10;
    localparam logic [3:0]  BP_ALL      = 4'hB;
    localparam logic [10:0] SECT_NUM    = 11'h400;
    // Status byte layout
    localparam int unsigned SR_WIP      = 0;
    localparam int unsigned SR_WEL      = 1;
    localparam int unsigned SR_LVL_LO   = 2;
    localparam int unsigned SR_TOPBOT   = 5;
    localparam int unsigned SR_LVL_HI   = 6;
    localparam logic [3:0]  RST_BP      = 4'h0;
    localparam logic        RST_TOPBOT  = 1'b0;
    // Idle levels of serial clock, chip select and data in
    localparam logic [2:0]  PIN_IDLE    = 3'h2;
    // Default opcodes
    localparam logic [7:0]  OP_READ_DEF = 8'h03;
    localparam logic [7:0]  OP_FAST_DEF = 8'h0B;
    localparam logic [7:0]  OP_RDSR_DEF = 8'h05;
    localparam logic [7:0]  OP_WRSR_DEF = 8'h01;
    localparam logic [7:0]  OP_WREN_DEF = 8'h06;
    localparam logic [31:0] MEM_TOP_DEF = 32'hFFFFFFFF;
    typedef enum logic [2:0] {
        ST_OPC   = 3'b000,
        ST_ADDR  = 3'b001,
        ST_DUMMY = 3'b010,
        ST_DATA  = 3'b011,
        ST_WSR   = 3'b100,
        ST_STAT  = 3'b101,
        ST_WREN  = 3'b110,
        ST_IGN   = 3'b111
    } srfp_st_t;
endpackage

// ===== hw/srfp_sync.sv
// Two-flop synchroniser for a group of independent pin levels.
// Assumes each bit is a slow level relative to clk_i.
`timescale 1ns/1ps
module srfp_sync #(
    parameter int unsigned  W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } srfp_sync_t;
    srfp_sync_t r_ff, nxt_r;
    always_comb begin
        nxt_r    = r_ff;
        nxt_r.s1 = d_i;
        nxt_r.s2 = r_ff.s1;
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_ff <= {RST_VAL, RST_VAL};
        end else begin
            r_ff <= nxt_r;
        end
    end
    assign q_o = r_ff.s2;
endmodule // srfp_sync

// ===== test/srfp_host.sv
// Host-side partner: drives chip select, serial clock and data in; answers fetches.
// Assumes a 10 MHz clk_i; serial clock period is 8 clk and stands low between frames.
`timescale 1ns/1ps
module srfp_host (
    input  wire logic        clk_i,
    output logic             cs_n_o,
    output logic             sck_o,
    output logic             si_o,
    input  wire logic        so_i,
    input  wire logic        fetch_req_i,
    input  wire logic [31:0] fetch_addr_i,
    output logic             fetch_valid_o,
    output logic      [7:0]  fetch_data_o
);
    logic [7:0]  rx_q[$];
    logic [7:0]  sh;
    logic [31:0] pa;
    logic        pend = 1'b0;
    logic        slow = 1'b0;
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        fetch_valid_o = 1'b0;
        fetch_data_o = 8'h00;
    end
    function automatic logic [7:0] mem_byte(input logic [31:0] a);
        return a[7:0] ^ a[15:8] ^ a[31:24] ^ 8'h3C;
    endfunction
    task automatic clks(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // Frame: nb command bits MSB first, then nr clocks of readback
    task automatic frame(input logic [63:0] bits, input int nb, input int nr);
        rx_q.delete();
        @(posedge clk_i) cs_n_o <= 1'b0;
        clks(4);
        for (int i = 0; i < nb + nr; i++) begin
            @(posedge clk_i) si_o <= (i < nb) ? bits[nb-1-i] : ~si_o;
            clks(2);
            @(posedge clk_i) sck_o <= 1'b1;
            clks(3);
            if (i >= nb) sh = {sh[6:0], so_i};
            if (i >= nb && (i - nb) % 8 == 7) rx_q.push_back(sh);
            @(posedge clk_i) sck_o <= 1'b0;
        end
        @(posedge clk_i) cs_n_o <= 1'b1;
        si_o <= ~si_o;
        clks(6);
    endtask
    // Memory answers in 1 or 2 clk by turns; data toggles outside the pulse
    always @(posedge clk_i) begin
        fetch_valid_o <= 1'b0;
        fetch_data_o <= ~fetch_data_o;
        if (pend) begin
            fetch_valid_o <= 1'b1;
            fetch_data_o <= mem_byte(pa);
            pend <= 1'b0;
        end
        if (fetch_req_i) begin
            slow <= ~slow;
            pa <= fetch_addr_i;
            if (slow) pend <= 1'b1;
            else begin
                fetch_valid_o <= 1'b1;
                fetch_data_o <= mem_byte(fetch_addr_i);
            end
        end
    end
endmodule // srfp_host

// ===== test/tb_top.sv
// Testbench for srfp_main: protection table, status write, plain and fast reads.
// Assumes srfp_host as far side and a shortened status write time.
`timescale 1ns/1ps
module tb_top;
    import srfp_pkg::*;
    localparam int WS = 200;
    typedef struct packed {logic t; logic [3:0] b; logic [9:0] s; logic p;} srfp_tbrow_t;
    localparam srfp_tbrow_t ROWS [11] = '{
        '{1'h0, 4'h0, 10'h3FF, 1'h0}, '{1'h0, 4'h1, 10'h3FF, 1'h1},
        '{1'h0, 4'h1, 10'h3FE, 1'h0}, '{1'h0, 4'hA, 10'h200, 1'h1},
        '{1'h0, 4'hA, 10'h1FF, 1'h0}, '{1'h0, 4'hB, 10'h000, 1'h1},
        '{1'h1, 4'h8, 10'h07F, 1'h1}, '{1'h1, 4'h8, 10'h080, 1'h0},
        '{1'h1, 4'hA, 10'h1FF, 1'h1}, '{1'h1, 4'hF, 10'h3FF, 1'h1},
        '{1'h1, 4'h0, 10'h000, 1'h0}};
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        cs_n_i, serial_clock_pin_i, serial_in_line_i, serial_out_line_o;
    logic        serial_out_oe_o, sector_protected_o, top_bottom_select_o;
    logic        status_wel_o, status_wip_o, fetch_req_o, fetch_valid_i;
    logic        addr4_i = 1'b0;
    logic        ext_busy_i = 1'b0;
    logic        oe_seen = 1'b0;
    logic [9:0]  sector_query_i = 10'h000;
    logic [3:0]  block_protect_level_o;
    logic [31:0] fetch_addr_o;
    logic [7:0]  fetch_data_i;
    int          n_mismatch = 0;
    int          tests_run = 0;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (serial_out_oe_o === 1'b1) oe_seen = 1'b1;
    // Released output line has no pull-up: it shows the inverse of the last bit
    wire         so_line = serial_out_oe_o ? serial_out_line_o : ~serial_out_line_o;
    srfp_main #(.WS_CYCLES(WS)) DUT (.clk_i, .nrst_i, .cs_n_i, .serial_clock_pin_i,
        .serial_in_line_i, .serial_out_line_o, .serial_out_oe_o, .addr4_i, .ext_busy_i,
        .sector_query_i, .sector_protected_o, .block_protect_level_o, .top_bottom_select_o,
        .status_wel_o, .status_wip_o, .fetch_req_o, .fetch_addr_o, .fetch_valid_i,
        .fetch_data_i);
    srfp_host HOST (.clk_i(clk_i), .cs_n_o(cs_n_i), .sck_o(serial_clock_pin_i),
        .si_o(serial_in_line_i), .so_i(so_line), .fetch_req_i(fetch_req_o),
        .fetch_addr_i(fetch_addr_o), .fetch_valid_o(fetch_valid_i),
        .fetch_data_o(fetch_data_i));
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr_status(input logic t, input logic [3:0] b, input logic en);
        if (en) HOST.frame({56'h0, OP_WREN_DEF}, 8, 0);
        HOST.frame({48'h0, OP_WRSR_DEF, 1'b0, b[3], t, b[2:0], 2'b11}, 16, 0);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 2 * WS && status_wip_o !== 1'b0; i++) @(posedge clk_i);
        chk_bit(status_wip_o, 1'b0);
    endtask
    task automatic read_chk(input logic [63:0] cmd, input int nb, input int nr,
                            input logic [31:0] a, input int skip);
        HOST.frame(cmd, nb, nr);
        for (int k = skip; k < nr / 8; k++) begin
            chk_byte(HOST.rx_q[k], HOST.mem_byte(a + k - skip));
        end
    endtask
    initial begin
        #(30000 * 100);
        n_mismatch++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        HOST.clks(4);
        foreach (ROWS[i]) begin
            wr_status(ROWS[i].t, ROWS[i].b, 1'b1);
            wait_idle();
            chk_byte({4'h0, block_protect_level_o}, {4'h0, ROWS[i].b});
            chk_bit(top_bottom_select_o, ROWS[i].t);
            chk_bit(status_wel_o, 1'b0);
            @(posedge clk_i) sector_query_i <= ROWS[i].s;
            HOST.clks(2);
            chk_bit(sector_protected_o, ROWS[i].p);
        end
        wr_status(1'b0, 4'hF, 1'b0);
        HOST.clks(WS + 20);
        chk_byte({4'h0, block_protect_level_o}, 8'h00);
        chk_bit(top_bottom_select_o, 1'b1);
        HOST.frame({56'h0, OP_WREN_DEF}, 8, 0);
        chk_bit(status_wel_o, 1'b1);
        HOST.frame({48'h0, OP_WRSR_DEF, 8'h0F}, 16, 0);
        HOST.frame({56'h0, OP_RDSR_DEF}, 8, 8);
        chk_byte(HOST.rx_q[0], 8'h23);
        wait_idle();
        HOST.frame({56'h0, OP_RDSR_DEF}, 8, 8);
        chk_byte(HOST.rx_q[0], 8'h0C);
        read_chk({32'h0, OP_READ_DEF, 24'h0000F8}, 32, 144, 32'h000000F8, 0);
        addr4_i <= 1'b1;
        read_chk({24'h0, OP_FAST_DEF, 32'hFFFFFFFE}, 40, 32, 32'hFFFFFFFE, 1);
        addr4_i <= 1'b0;
        HOST.frame({32'h0, OP_FAST_DEF, 24'h000010}, 32, DUMMY_DEF + 4);
        chk_bit(serial_out_oe_o, 1'b0);
        @(posedge clk_i) ext_busy_i <= 1'b1;
        HOST.clks(3);
        chk_bit(status_wip_o, 1'b1);
        oe_seen = 1'b0;
        HOST.frame({32'h0, OP_READ_DEF, 24'h000020}, 32, 16);
        HOST.frame({32'h0, OP_FAST_DEF, 24'h000020}, 32, 24);
        chk_bit(oe_seen, 1'b0);
        @(posedge clk_i) ext_busy_i <= 1'b0;
        HOST.clks(3);
        chk_bit(status_wip_o, 1'b0);
        oe_seen = 1'b0;
        HOST.frame({32'h0, 8'hFF, 24'h000020}, 32, 16);
        chk_bit(oe_seen, 1'b0);
        @(posedge clk_i) nrst_i <= 1'b0;
        HOST.clks(2);
        chk_byte({4'h0, block_protect_level_o}, 8'h00);
        chk_bit(top_bottom_select_o, 1'b0);
        chk_bit(serial_out_oe_o, 1'b0);
        end_sim();
    end
endmodule // tb_top
